// ### hdl/dmc_control_port.sv
// I2C / SPI control port with register store and burst addressing
//
// Functional notes
// - Start in I2C; switch to SPI after three low pulses on select.
// - The three switching writes are ignored; SPI then stays until reset.
// - Registers read and write; writes need master clock except 0x4000 and 0x4002.
// - Next two bytes form the subaddress, high byte first, and select the register.
// - Data starts at the fourth byte; word length depends on the register.
// - Four pins shared: I2C clock, data, two id inputs; SPI clock, out, in, select.
// - Subaddress advances after each word; stop or select high ends the burst.
// - Registers are one byte except the six-byte synthesizer word.
// - Subaddress steps by one after every word, hole or not, except a refused write past the top.
// - Hole addresses ignore writes and read back as 0x00.
// - In I2C mode the port is slave only and never starts a transfer.
// - Bus address is 01110 followed by the two id pin levels.
// - First byte LSB one means read, zero means write.
// - I2C: invalid subaddress is not acknowledged and the port goes idle.
// - SPI samples on rising clock, shifts out on falling; out floats unless reading.
`timescale 1ns/1ns
module dmc_control_port (
    input  wire logic                   clk,
    input  wire logic                   rst,
    input  wire logic                   ctrl_serial_clock,
    input  wire logic                   data_pin_in,
    output logic                        data_pin_out,
    output logic                        data_pin_oe_n,
    input  wire logic                   bus_id_pin_hi,
    input  wire logic                   bus_id_pin_lo,
    input  wire logic                   mclk_valid,
    output dmc_pkg::dmc_reg_write_t     reg_write,
    output logic                        spi_mode
);
    // Pin synchronisers; only the second stage and its delayed copy feed logic
    logic [4:0] meta;
    logic [4:0] sync;
    logic [4:0] prev;
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            meta <= dmc_pkg::PIN_IDLE; // Idle levels, so release shows no false edge
            sync <= dmc_pkg::PIN_IDLE;
            prev <= dmc_pkg::PIN_IDLE;
        end else begin
            meta <= {mclk_valid, bus_id_pin_lo, bus_id_pin_hi, data_pin_in, ctrl_serial_clock};
            sync <= meta;
            prev <= sync;
        end
    end

    // Pin roles per mode
    logic scl, sda, ctrl_serial_in, ctrl_select_n, mclk_ok;
    logic clk_rise, clk_fall, sel_rise, sel_fall, i2c_start, i2c_stop;
    assign scl            = sync[0];
    assign sda            = sync[1];
    assign ctrl_serial_in = sync[2];
    assign ctrl_select_n  = sync[3];
    assign mclk_ok        = sync[4];
    assign clk_rise       = sync[0] & ~prev[0];
    assign clk_fall       = ~sync[0] & prev[0];
    assign sel_rise       = sync[3] & ~prev[3];
    assign sel_fall       = ~sync[3] & prev[3];
    assign i2c_start      = scl & prev[0] & prev[1] & ~sda;
    assign i2c_stop       = scl & prev[0] & ~prev[1] & sda;

    // Register store; the long synthesizer word lives apart from the byte array
    logic [7:0]  regs [0:dmc_pkg::REG_COUNT-1];
    logic [47:0] pll_q;

    function automatic logic is_hole(input logic [15:0] a);
        is_hole = (a == dmc_pkg::HOLE_A) || (a == dmc_pkg::HOLE_C)
               || (a >= dmc_pkg::HOLE_B_LO && a <= dmc_pkg::HOLE_B_HI)
               || (a >= dmc_pkg::HOLE_D_LO && a <= dmc_pkg::HOLE_D_HI);
    endfunction

    function automatic logic in_map(input logic [15:0] a);
        in_map = (a >= dmc_pkg::REG_BASE) && (a <= dmc_pkg::REG_LAST);
    endfunction

    // Past the top of the map a read keeps returning the highest register
    function automatic logic [7:0] fetch(input logic [15:0] a, input logic [2:0] wb);
        logic [15:0] c;
        c = (a > dmc_pkg::REG_LAST) ? dmc_pkg::REG_LAST : a;
        if (c == dmc_pkg::PLL_ADDR)
            fetch = pll_q[{dmc_pkg::PLL_LAST_BYTE - wb, 3'h0} +: 8];
        else if (is_hole(c) || !in_map(c))
            fetch = dmc_pkg::HOLE_READ;
        else
            fetch = regs[c[5:0]];
    endfunction

    // Protocol state
    dmc_pkg::dmc_state_t     state, next_state;
    dmc_pkg::dmc_reg_write_t next_wr;
    logic [1:0]  pulse_cnt, next_pulse_cnt;
    logic        next_spi_mode;
    logic [3:0]  bitcnt, next_bitcnt;
    logic [7:0]  shreg, next_shreg, tx, next_tx, rx_byte;
    logic [1:0]  idx, next_idx;
    logic        rd, next_rd, drive_low, next_drive_low, sdo, next_sdo;
    logic [15:0] sub, next_sub, new_sub;
    logic [2:0]  wb, next_wb;
    logic [39:0] stage, next_stage;
    logic        byte_done, ack, allowed, mem_we, pll_we, next_oe_n;

    // Next-state logic shared by both modes
    always_comb begin
        next_state     = state;
        next_pulse_cnt = pulse_cnt;
        next_spi_mode  = spi_mode;
        next_bitcnt    = bitcnt;
        next_shreg     = shreg;
        next_tx        = tx;
        next_idx       = idx;
        next_rd        = rd;
        next_sub       = sub;
        next_wb        = wb;
        next_stage     = stage;
        next_drive_low = drive_low;
        next_sdo       = sdo;
        next_wr        = '0;
        mem_we         = 1'b0;
        pll_we         = 1'b0;
        byte_done      = 1'b0;
        ack            = 1'b1;
        rx_byte        = {shreg[6:0], spi_mode ? ctrl_serial_in : sda};
        new_sub        = {sub[15:8], rx_byte};
        allowed        = mclk_ok || sub == dmc_pkg::REG_BASE || sub == dmc_pkg::PLL_ADDR;
        // Mode latch counts select pulses; one-way, so it cannot fall back
        if (!spi_mode && sel_rise) begin
            next_pulse_cnt = pulse_cnt + 2'h1;
            if (next_pulse_cnt == dmc_pkg::SPI_LATCH_CNT)
                next_spi_mode = 1'b1;
        end
        if (!spi_mode) begin
            // Slave only: nothing moves until the host makes a start
            if (i2c_start) begin
                next_state     = dmc_pkg::ST_RX;
                next_bitcnt    = 4'h0;
                next_idx       = 2'h0;
                next_rd        = 1'b0;
                next_drive_low = 1'b0;
            end else if (i2c_stop) begin
                next_state     = dmc_pkg::ST_IDLE;
                next_drive_low = 1'b0;
            end else begin
                unique case (state)
                    dmc_pkg::ST_IDLE: begin
                    end
                    dmc_pkg::ST_RX: if (clk_rise) begin
                        next_shreg  = rx_byte;
                        next_bitcnt = bitcnt + 4'h1;
                        byte_done   = (bitcnt == dmc_pkg::LAST_BIT);
                    end
                    dmc_pkg::ST_ACKW: if (clk_fall) begin
                        next_drive_low = 1'b1;
                        next_state     = dmc_pkg::ST_ACK;
                    end
                    dmc_pkg::ST_ACK: if (clk_fall) begin
                        next_drive_low = 1'b0;
                        next_bitcnt    = 4'h0;
                        next_state     = dmc_pkg::ST_RX;
                        if (rd) begin
                            next_drive_low = ~tx[7];
                            next_tx        = {tx[6:0], 1'b0};
                            next_bitcnt    = 4'h1;
                            next_state     = dmc_pkg::ST_TX;
                        end
                    end
                    dmc_pkg::ST_TX: if (clk_fall) begin
                        if (bitcnt == dmc_pkg::BYTE_BITS) begin
                            next_drive_low = 1'b0;
                            next_state     = dmc_pkg::ST_MACK;
                        end else begin
                            next_drive_low = ~tx[7];
                            next_tx        = {tx[6:0], 1'b0};
                            next_bitcnt    = bitcnt + 4'h1;
                        end
                    end
                    dmc_pkg::ST_MACK: if (clk_rise) begin
                        next_state = dmc_pkg::ST_IDLE;
                        if (!sda) begin
                            if (sub == dmc_pkg::PLL_ADDR && wb != dmc_pkg::PLL_LAST_BYTE) begin
                                next_wb = wb + 3'h1;
                            end else begin
                                next_wb  = 3'h0;
                                next_sub = sub + 16'h0001;
                            end
                            next_tx     = fetch(next_sub, next_wb);
                            next_bitcnt = 4'h0;
                            next_state  = dmc_pkg::ST_TX;
                        end
                    end
                endcase
            end
        end else begin
            // SPI frame runs from select low to select high
            if (sel_fall) begin
                next_state  = dmc_pkg::ST_RX;
                next_bitcnt = 4'h0;
                next_idx    = 2'h0;
                next_rd     = 1'b0;
            end else if (sel_rise) begin
                next_state = dmc_pkg::ST_IDLE;
            end else if (state == dmc_pkg::ST_RX && clk_rise) begin
                next_shreg  = rx_byte;
                next_bitcnt = bitcnt + 4'h1;
                byte_done   = (bitcnt == dmc_pkg::LAST_BIT);
            end else if (state == dmc_pkg::ST_RX && clk_fall && rd && idx == dmc_pkg::IDX_DATA) begin
                next_sdo = tx[7];
                next_tx  = {tx[6:0], 1'b0};
            end
        end
        // Byte framing: address, subaddress high, low, then data
        if (byte_done) begin
            next_bitcnt = 4'h0;
            unique case (idx)
                2'h0: begin
                    if (!spi_mode && rx_byte[7:1] != {dmc_pkg::CHIP_ADDR_HI, sync[2], sync[3]})
                        ack = 1'b0;
                    next_rd = rx_byte[0];
                    next_tx = fetch(sub, wb);
                end
                2'h1: next_sub[15:8] = rx_byte;
                2'h2: begin
                    ack      = in_map(new_sub);
                    next_sub = new_sub;
                    next_wb  = 3'h0;
                    next_tx  = fetch(new_sub, 3'h0);
                end
                default: begin
                    if (!rd && sub > dmc_pkg::REG_LAST) begin
                        ack = 1'b0;
                    end else begin
                        if (!rd && sub == dmc_pkg::PLL_ADDR) begin
                            next_stage = {stage[31:0], rx_byte};
                            if (wb == dmc_pkg::PLL_LAST_BYTE && allowed) begin
                                pll_we  = 1'b1;
                                next_wr = '{1'b1, sub, {stage, rx_byte}};
                            end
                        end else if (!rd && !is_hole(sub) && allowed) begin
                            mem_we  = 1'b1;
                            next_wr = '{1'b1, sub, {40'h0, rx_byte}};
                        end
                        if (sub == dmc_pkg::PLL_ADDR && wb != dmc_pkg::PLL_LAST_BYTE) begin
                            next_wb = wb + 3'h1;
                        end else begin
                            next_wb  = 3'h0;
                            next_sub = sub + 16'h0001;
                        end
                        next_tx = fetch(next_sub, next_wb);
                    end
                end
            endcase
            if (idx != dmc_pkg::IDX_DATA)
                next_idx = idx + 2'h1;
            if (!ack)
                next_state = dmc_pkg::ST_IDLE;
            else if (!spi_mode)
                next_state = dmc_pkg::ST_ACKW;
        end
        // SPI readback line floats unless a read is under way; the I2C line is driven only to pull low for an ack or a zero bit
        if (spi_mode)
            next_oe_n = ~(next_rd && next_idx == dmc_pkg::IDX_DATA
                          && next_state == dmc_pkg::ST_RX && !ctrl_select_n);
        else
            next_oe_n = ~next_drive_low;
    end

    // State registers and pin drivers
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            state         <= dmc_pkg::ST_IDLE;
            pulse_cnt     <= 2'h0;
            spi_mode      <= 1'b0;
            bitcnt        <= 4'h0;
            shreg         <= 8'h00;
            tx            <= 8'h00;
            idx           <= 2'h0;
            rd            <= 1'b0;
            sub           <= 16'h0000;
            wb            <= 3'h0;
            stage         <= 40'h0;
            drive_low     <= 1'b0;
            sdo           <= 1'b0;
            reg_write     <= '0;
            data_pin_out  <= 1'b0;
            data_pin_oe_n <= 1'b1;
        end else begin
            state         <= next_state;
            pulse_cnt     <= next_pulse_cnt;
            spi_mode      <= next_spi_mode;
            bitcnt        <= next_bitcnt;
            shreg         <= next_shreg;
            tx            <= next_tx;
            idx           <= next_idx;
            rd            <= next_rd;
            sub           <= next_sub;
            wb            <= next_wb;
            stage         <= next_stage;
            drive_low     <= next_drive_low;
            sdo           <= next_sdo;
            reg_write     <= next_wr;
            data_pin_out  <= spi_mode ? next_sdo : 1'b0; // Open drain pulls low only in I2C; SPI drives sdo at both levels
            data_pin_oe_n <= next_oe_n;
        end
    end

    // Register array write port
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < dmc_pkg::REG_COUNT; i++)
                regs[i] <= dmc_pkg::REG_RESET;
            pll_q <= 48'h0;
        end else begin
            if (mem_we)
                regs[sub[5:0]] <= rx_byte;
            if (pll_we)
                pll_q <= {stage, rx_byte};
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    spi_mode_sticky_a: assert property (spi_mode |=> spi_mode)
        else $error("spi mode dropped");
    mode_switch_a: assert property (!spi_mode && sel_rise && pulse_cnt == 2'h2 |=> spi_mode)
        else $error("spi mode not entered on third pulse");
    mclk_gate_a: assert property (reg_write.valid && reg_write.addr != dmc_pkg::REG_BASE
        && reg_write.addr != dmc_pkg::PLL_ADDR |-> $past(mclk_ok))
        else $error("write without master clock");
    hole_write_a: assert property (reg_write.valid |-> !is_hole(reg_write.addr))
        else $error("write landed in an address hole");
    pll_word_a: assert property (reg_write.valid && reg_write.addr == dmc_pkg::PLL_ADDR
        |-> $past(wb) == dmc_pkg::PLL_LAST_BYTE)
        else $error("long word committed early");
    sub_step_a: assert property (mem_we |=> sub == $past(sub) + 16'h0001 && wb == 3'h0)
        else $error("subaddress did not step by one");
    bad_sub_a: assert property (!spi_mode && byte_done && idx == 2'h2 && !in_map(new_sub)
        && !i2c_start |=> state == dmc_pkg::ST_IDLE ##1 data_pin_oe_n)
        else $error("invalid subaddress not refused");
    i2c_drive_a: assert property (!spi_mode && !data_pin_oe_n |-> !data_pin_out)
        else $error("i2c data driven high");
    spi_float_a: assert property (spi_mode && !data_pin_oe_n |-> rd && idx == 2'h3)
        else $error("spi output driven outside a read");
endmodule

// ### hdl/dmc_pkg.sv
// Shared constants and types of the dual-mode control port
package dmc_pkg;
    // Register space bounds and special addresses
    localparam logic [15:0] REG_BASE      = 16'h4000;
    localparam logic [15:0] REG_LAST      = 16'h4036;
    localparam logic [15:0] PLL_ADDR      = 16'h4002;
    // Address holes
    localparam logic [15:0] HOLE_A        = 16'h4001;
    localparam logic [15:0] HOLE_B_LO     = 16'h4003;
    localparam logic [15:0] HOLE_B_HI     = 16'h4007;
    localparam logic [15:0] HOLE_C        = 16'h402E;
    localparam logic [15:0] HOLE_D_LO     = 16'h4032;
    localparam logic [15:0] HOLE_D_HI     = 16'h4035;
    // Word layout
    localparam int          REG_COUNT     = 55;
    localparam logic [2:0]  PLL_LAST_BYTE = 3'h5;
    localparam logic [7:0]  REG_RESET     = 8'h00;
    localparam logic [7:0]  HOLE_READ     = 8'h00;
    localparam logic [3:0]  LAST_BIT      = 4'h7;
    localparam logic [3:0]  BYTE_BITS     = 4'h8;
    localparam logic [1:0]  IDX_DATA      = 2'h3;
    // Bus identity and mode switch
    localparam logic [4:0]  CHIP_ADDR_HI  = 5'h0E;
    // Synchroniser start levels {mclk, select, id hi, data, clock}: idle pins high
    localparam logic [4:0]  PIN_IDLE      = 5'h0F;
    localparam logic [1:0]  SPI_LATCH_CNT = 2'h3;

    typedef enum logic [2:0] {ST_IDLE, ST_RX, ST_ACKW, ST_ACK, ST_TX, ST_MACK} dmc_state_t;

    // One completed register word as seen by the core
    typedef struct packed {
        logic        valid;
        logic [15:0] addr;
        logic [47:0] data;
    } dmc_reg_write_t;
endpackage

// ### testbench/dmc_host_model.sv
// Host controller model that drives the I2C or SPI side of the control port
`timescale 1ns/1ns
module dmc_host_model (
    input  wire logic clk,
    input  wire logic sda_line,
    output logic      scl,
    output logic      sda_o,
    output logic      id_hi,
    output logic      id_lo
);
    // Half of the 800 ns serial clock, counted in system clocks
    localparam int HALF = 4;

    // Bus idle, select high, chip id pins both high
    initial begin
        scl = 1'b1;
        sda_o = 1'b1;
        id_hi = 1'b1;
        id_lo = 1'b1;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Mid-cycle sample keeps clear of the design's own edge updates
    task automatic look(output logic v);
        @(negedge clk);
        v = sda_line;
    endtask

    // Also serves as repeated start; master only, device never starts
    // Tasks start and end just after an edge, so every phase is HALF clocks
    task automatic i2c_start();
        sda_o <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_o <= 1'b0;
        tick(HALF);
        scl <= 1'b0;
    endtask

    task automatic i2c_stop();
        sda_o <= 1'b0;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        sda_o <= 1'b1;
        tick(HALF);
    endtask

    // MSB first; data changes with the clock fall, zero hold is legal here
    task automatic i2c_put(input logic [7:0] b, output logic ack);
        logic v;
        for (int i = 7; i >= 0; i--) begin
            sda_o <= b[i];
            tick(HALF);
            scl <= 1'b1;
            tick(HALF);
            scl <= 1'b0;
        end
        sda_o <= 1'b1;
        tick(HALF);
        scl <= 1'b1;
        look(v);
        ack = ~v;
        tick(HALF);
        scl <= 1'b0;
    endtask

    // Line released while the device shifts; last byte is refused by the host
    task automatic i2c_get(input logic last, output logic [7:0] b);
        for (int i = 7; i >= 0; i--) begin
            sda_o <= 1'b1;
            tick(HALF);
            scl <= 1'b1;
            look(b[i]);
            tick(HALF);
            scl <= 1'b0;
        end
        sda_o <= last;
        tick(HALF);
        scl <= 1'b1;
        tick(HALF);
        scl <= 1'b0;
    endtask

    // Select low opens a frame; three of them latch the SPI mode
    task automatic spi_sel(input logic lvl);
        @(posedge clk);
        id_lo <= lvl;
        tick(HALF);
    endtask

    // Clock idles high; data set on fall, taken by device on rise
    task automatic spi_byte(input logic [7:0] tx, output logic [7:0] rx);
        for (int i = 7; i >= 0; i--) begin
            scl <= 1'b0;
            id_hi <= tx[i];
            tick(HALF);
            scl <= 1'b1;
            look(rx[i]);
            tick(HALF);
        end
    endtask
endmodule

// ### testbench/test_dmc_control_port.sv
// Self-checking bench for the dual-mode control port
`timescale 1ns/1ns
module test_dmc_control_port;
    logic                    clk;
    logic                    rst;
    logic                    mclk_valid;
    logic                    tgl;
    logic                    scl;
    logic                    sda_o;
    logic                    id_hi;
    logic                    id_lo;
    logic                    sda_line;
    logic                    d_out;
    logic                    oe_n;
    logic                    spi;
    dmc_pkg::dmc_reg_write_t rw;
    dmc_pkg::dmc_reg_write_t last_rw;
    int                      err_total;
    int                      checks;
    int                      wr_cnt;
    logic [7:0]              q[$];
    logic [15:0]             ak;
    logic [7:0]              rx;

    dmc_control_port u_dut (.clk(clk), .rst(rst), .ctrl_serial_clock(scl),
        .data_pin_in(sda_line), .data_pin_out(d_out), .data_pin_oe_n(oe_n),
        .bus_id_pin_hi(id_hi), .bus_id_pin_lo(id_lo), .mclk_valid(mclk_valid),
        .reg_write(rw), .spi_mode(spi));
    dmc_host_model u_host (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_o(sda_o),
        .id_hi(id_hi), .id_lo(id_lo));

    // Pull-up wired-AND in I2C; a released SPI output shows a moving pattern
    assign sda_line = spi ? (oe_n ? tgl : d_out) : (sda_o & (oe_n | d_out));

    always #50 clk = ~clk;

    // Count committed words; a missed or extra pulse shows in the count
    always @(posedge clk) begin
        tgl <= ~tgl;
        if (rw.valid === 1'b1) begin
            wr_cnt <= wr_cnt + 1;
            last_rw <= rw;
        end
    end

    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got %h exp %h", $time, got, exp);
        end
    endtask

    task automatic close_out();
        $display("Checks %0d mismatches %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask

    task automatic i2c_wr(input logic [7:0] adr, input logic [15:0] sub,
                          input logic [7:0] d[$]);
        logic a;
        ak = 16'h0000;
        u_host.i2c_start();
        u_host.i2c_put(adr, a);
        ak[0] = a;
        u_host.i2c_put(sub[15:8], a);
        ak[1] = a;
        u_host.i2c_put(sub[7:0], a);
        ak[2] = a;
        foreach (d[k]) begin
            u_host.i2c_put(d[k], a);
            ak[k + 3] = a;
        end
        u_host.i2c_stop();
    endtask

    task automatic i2c_rd(input logic [15:0] sub, input int n);
        logic       a;
        logic [7:0] b;
        q = {};
        u_host.i2c_start();
        u_host.i2c_put(8'h76, a);
        u_host.i2c_put(sub[15:8], a);
        u_host.i2c_put(sub[7:0], a);
        u_host.i2c_start();
        u_host.i2c_put(8'h77, a);
        for (int k = 0; k < n; k++) begin
            u_host.i2c_get(k == n - 1, b);
            q.push_back(b);
        end
        u_host.i2c_stop();
    endtask

    task automatic t_burst();
        int c;
        c = wr_cnt;
        i2c_wr(8'h76, 16'h4010, {8'hA5, 8'h5A});
        chk(ak[4:0], 5'h1F);
        chk(wr_cnt - c, 2);
        chk({last_rw.addr, last_rw.data[7:0]}, 24'h40115A);
        i2c_rd(16'h4010, 2);
        chk({q[0], q[1]}, 16'hA55A);
        $display("done t_burst");
    endtask

    task automatic t_long();
        int c;
        mclk_valid <= 1'b0;
        c = wr_cnt;
        i2c_wr(8'h76, 16'h4000, {8'h11, 8'h22, 8'h01, 8'h23, 8'h45, 8'h67, 8'h89, 8'hAB, 8'hCD});
        chk(ak[11:0], 12'hFFF);
        chk(wr_cnt - c, 2);
        chk({last_rw.addr, last_rw.data}, 64'h4002_0123456789AB);
        i2c_wr(8'h76, 16'h4010, {8'h3C});
        chk(wr_cnt - c, 2);
        i2c_rd(16'h4000, 2);
        chk({q[0], q[1]}, 16'h1100);
        i2c_rd(16'h4002, 7);
        chk({q[0], q[1], q[2], q[3], q[4], q[5]}, 48'h0123456789AB);
        chk(q[6], 8'h00);
        i2c_rd(16'h4003, 1);
        chk(q[0], 8'h00);
        i2c_rd(16'h4010, 1);
        chk(q[0], 8'hA5);
        mclk_valid <= 1'b1;
        $display("done t_long");
    endtask

    task automatic t_refuse();
        int c;
        c = wr_cnt;
        i2c_wr(8'h70, 16'h4010, {8'h99});
        chk(ak[0], 1'b0);
        i2c_wr(8'h76, 16'h4037, {8'h99});
        chk(ak[2:0], 3'h3);
        chk(wr_cnt - c, 0);
        i2c_wr(8'h76, 16'h4036, {8'h77, 8'h88});
        chk(ak[4:0], 5'h0F);
        chk({wr_cnt - c, last_rw.addr}, 48'h00000001_4036);
        chk({oe_n, spi}, 2'b10);
        $display("done t_refuse");
    endtask

    task automatic t_spi();
        int c;
        c = wr_cnt;
        for (int f = 0; f < 3; f++) begin
            chk(spi, 1'b0);
            u_host.spi_sel(1'b0);
            u_host.spi_byte(8'h00, rx);
            u_host.spi_byte(8'h40, rx);
            u_host.spi_byte(8'h30, rx);
            u_host.spi_byte(8'hEE, rx);
            u_host.spi_sel(1'b1);
        end
        chk({spi, oe_n}, 2'b11);
        chk(wr_cnt - c, 0);
        u_host.spi_sel(1'b0);
        u_host.spi_byte(8'h00, rx);
        u_host.spi_byte(8'h40, rx);
        u_host.spi_byte(8'h20, rx);
        u_host.spi_byte(8'h96, rx);
        chk(oe_n, 1'b1);
        u_host.spi_sel(1'b1);
        chk({last_rw.addr, last_rw.data[7:0]}, 24'h402096);
        u_host.spi_sel(1'b0);
        u_host.spi_byte(8'h01, rx);
        u_host.spi_byte(8'h40, rx);
        u_host.spi_byte(8'h20, rx);
        u_host.spi_byte(8'h00, rx);
        chk(rx, 8'h96);
        u_host.spi_byte(8'h00, rx);
        chk({rx, oe_n}, 9'h000);
        u_host.spi_sel(1'b1);
        u_host.tick(4);
        chk({oe_n, spi}, 2'b11);
        $display("done t_spi");
    endtask

    // Whole run is about 0.66 ms of traffic; over four times that marks a hang
    initial begin
        #3000000;
        err_total++;
        close_out();
    end

    initial begin
        clk = 1'b0;
        rst = 1'b1;
        mclk_valid = 1'b1;
        tgl = 1'b0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        chk({oe_n, spi, rw.valid}, 3'h4);
        u_host.tick(6);
        t_burst();
        t_long();
        t_refuse();
        t_spi();
        close_out();
    end
endmodule
